// ===== vir_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  voltage-code receiver.
  Assumes a 20 MHz device clock and that it is included by its bare name.
*/
// Behaviour
// (RULE1) Select 00 invalid, 01 core, 10 nest, 11 unused; code goes to selected rail.
// (RULE2) Invalid select means standby; the code is meaningless and ignored.
// (RULE3) Host writes boot setpoints over SPI: core 1.1 V, nest 0.9 V.
// (RULE4) After power-up the processor steps invalid, nest, invalid, core.
// (RULE5) Code and select are de-bounced together for 100 to 400 ns.
// (RULE6) The processor holds each new code and select stable for 500 ns.
// (RULE7) Pin codes are ignored unless the IO rail regulator is enabled.
// (RULE8) Each nest change passes through invalid before nest is selected again.
// (RULE9) With core selected, every de-bounced code change updates the core setpoint; the code updates the core image, and the setpoint only with source bit 0.
// (RULE10) Runtime core changes move the code one 12.5 mV step at a time.
// (RULE11) Setpoint changes ramp toward the target at 25 mV per ms.
// (RULE12) Read-only 7-bit image per rail, bit 7 reads zero, reset 0x7F.
// (RULE13) Codes 0-24 give 1.2 V, 12.5 mV less per code, 97-127 off.
// (RULE14) Source bit 0 follows pins, 1 follows the SPI latch register.
// (RULE15) Regulation-done toggles only for setpoint changes made through registers.
// (RULE16) Invalid or unused select holds both images and both setpoints.
`ifndef VIR_REGS_SVH
`define VIR_REGS_SVH

`define VIR_ADDR_W          9
`define VIR_ADDR_CORE_IMAGE 9'h1C9
`define VIR_ADDR_NEST_IMAGE 9'h1CA
`define VIR_ADDR_CORE_LATCH 9'h1CB
`define VIR_ADDR_NEST_LATCH 9'h1CC

`define VIR_CODE_MSB        6
`define VIR_SRC_BIT         7
`define VIR_IMAGE_RST       7'h7F
`define VIR_CORE_LATCH_RST  8'h20
`define VIR_NEST_LATCH_RST  8'h30

`define VIR_CODE_FLAT       7'h18
`define VIR_CODE_LAST_ON    7'h60
`define VIR_V_MAX           14'h2EE0
`define VIR_V_STEP          14'h007D

`define VIR_CLK_NS          50
`define VIR_DEB_MIN_NS      100
`define VIR_DEB_MAX_NS      400
`define VIR_DEB_CYC         (((`VIR_DEB_MIN_NS + `VIR_CLK_NS - 1) / `VIR_CLK_NS + \
                              `VIR_DEB_MAX_NS / `VIR_CLK_NS) / 2)
`define VIR_SLEW_UV_PER_MS  25000
`define VIR_CODE_STEP_UV    12500
`define VIR_RAMP_NS         (((`VIR_CODE_STEP_UV * 1000) / `VIR_SLEW_UV_PER_MS) * 1000)
`define VIR_RAMP_CYC        (`VIR_RAMP_NS / `VIR_CLK_NS)

`endif

// ===== vir_pkg.sv
/*
  Types of the voltage-code receiver: rail select codes and state records.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package vir_pkg;

  typedef enum logic [1:0] {
    SEL_INVALID = 2'b00,
    SEL_CORE    = 2'b01,
    SEL_NEST    = 2'b10,
    SEL_UNUSED  = 2'b11
  } vir_rail_sel_t;

  typedef struct packed {
    logic [8:0] sample;
    logic [8:0] stable;
    logic [3:0] cnt;
    logic       accept;
  } vir_deb_t;

  // Index 0 is the core rail, index 1 the nest rail.
  typedef struct packed {
    logic [1:0][6:0]  image;
    logic [1:0][7:0]  latch;
    logic [1:0][6:0]  ramp;
    logic [15:0]      tick;
    logic [1:0]       pend;
    logic [7:0]       rdata;
    logic [1:0][13:0] setpt;
    logic [1:0]       on;
    logic             done;
  } vir_state_t;

endpackage : vir_pkg

`default_nettype wire

// ===== vir_debounce.sv
/*
  Group de-bouncer for the select and code pins.
  Assumes pins synchronous to the clock and a hold time longer than the window.
*/
`default_nettype none
`include "vir_regs.svh"

module vir_debounce
  import vir_pkg::*;
#(
  parameter int CYC = `VIR_DEB_CYC
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Raw pin group and filtered result
  input  wire logic [8:0] pins,
  output logic      [8:0] stable,
  output logic            accept
);

  vir_deb_t cur;
  vir_deb_t nxt;

  ////////////////////////////////////////////////////////////////////////////

  // All nine bits restart one shared window, so a ringing select line can
  // never pair with a settled code from a different presentation.
  always_comb
  begin
    nxt        = cur;
    nxt.accept = 1'b0;
    if (pins != cur.sample)
    begin
      nxt.sample = pins; // RULE5
      nxt.cnt    = 4'h0;
    end
    else if (cur.cnt < 4'(CYC))
    begin
      nxt.cnt = cur.cnt + 4'h1;
      if (cur.cnt == 4'(CYC - 1) && cur.sample != cur.stable)
      begin
        nxt.stable = cur.sample; // RULE5
        nxt.accept = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur <= '{sample: {SEL_INVALID, `VIR_IMAGE_RST}, stable: {SEL_INVALID, `VIR_IMAGE_RST},
               cnt: 4'h0, accept: 1'b0};
    end
    else
    begin
      cur <= nxt;
    end
  end

  assign stable = cur.stable;
  assign accept = cur.accept;

endmodule : vir_debounce

`default_nettype wire

// ===== vir_receiver.sv
/*
  Voltage-code receiver: de-bounces the shared code and select pins, keeps a
  read-only image per rail, holds the register-written setpoints, picks the
  source per rail, ramps each rail toward its target and reports completion
  of register-driven changes.
  Assumes the register decoder in front of it presents one-cycle read and
  write strobes and that the analog regulator follows the setpoint outputs.
*/
`default_nettype none
`include "vir_regs.svh"

module vir_receiver
  import vir_pkg::*;
#(
  parameter int DEB_CYC  = `VIR_DEB_CYC,
  parameter int RAMP_CYC = `VIR_RAMP_CYC
)
(
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST,
  // Processor pins
  input  wire logic [1:0]             RAIL_SELECT_CODE,
  input  wire logic [6:0]             VOLTAGE_CODE,
  // IO rail regulator status
  input  wire logic                   IO_RAIL_EN,
  // Register access
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  input  wire logic [`VIR_ADDR_W-1:0] REG_ADDR,
  input  wire logic [7:0]             REG_WDATA,
  output logic      [7:0]             REG_RDATA,
  // Regulator setpoints, in units of 0.1 mV
  output logic      [13:0]            CORE_SETPOINT,
  output logic                        CORE_ON,
  output logic      [13:0]            NEST_SETPOINT,
  output logic                        NEST_ON,
  // Completion of register-driven changes
  output logic                        REGULATION_DONE
);

  localparam vir_state_t STATE_RST = '{
    image: {`VIR_IMAGE_RST, `VIR_IMAGE_RST},
    latch: {`VIR_NEST_LATCH_RST, `VIR_CORE_LATCH_RST},
    ramp:  {`VIR_IMAGE_RST, `VIR_IMAGE_RST},
    tick:  16'h0000,
    pend:  2'b00,
    rdata: 8'h00,
    setpt: {14'h0000, 14'h0000},
    on:    2'b00,
    done:  1'b1
  };

  vir_state_t      cur;
  vir_state_t      nxt;
  logic [8:0]      deb_stable;
  logic            deb_accept;
  vir_rail_sel_t   sel;
  logic [6:0]      code;
  logic            tick_hit;
  logic [1:0][6:0] old_tgt;
  logic [1:0][6:0] new_tgt;
  logic [1:0]      spi_set;
  logic [1:0][8:0] latch_addr;

  ////////////////////////////////////////////////////////////////////////////

  vir_debounce #(
    .CYC    (DEB_CYC)
  ) u_debounce (
    .clk    (CLK),
    .rst    (RST),
    .pins   ({RAIL_SELECT_CODE, VOLTAGE_CODE}),
    .stable (deb_stable),
    .accept (deb_accept)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Flat at the top, linear in 12.5 mV steps, zero once the rail is off.
  function automatic logic [13:0] code_to_setpoint(input logic [6:0] c);
    logic [13:0] steps;
    steps = 14'(c) - 14'(`VIR_CODE_FLAT);
    if (c <= `VIR_CODE_FLAT)
      code_to_setpoint = `VIR_V_MAX; // RULE13
    else if (c <= `VIR_CODE_LAST_ON)
      code_to_setpoint = `VIR_V_MAX - 14'(steps * `VIR_V_STEP); // RULE13
    else
      code_to_setpoint = 14'h0000; // RULE13
  endfunction : code_to_setpoint

  // Source bit set: the written code rules; clear: the pin image rules.
  function automatic logic [6:0] target_of(input logic [7:0] latch, input logic [6:0] image);
    target_of = latch[`VIR_SRC_BIT] ? latch[`VIR_CODE_MSB:0] : image; // RULE14
  endfunction : target_of

  ////////////////////////////////////////////////////////////////////////////

  assign sel        = vir_rail_sel_t'(deb_stable[8:7]);
  assign code       = deb_stable[6:0];
  assign latch_addr = {`VIR_ADDR_NEST_LATCH, `VIR_ADDR_CORE_LATCH};

  always_comb
  begin
    nxt      = cur;
    nxt.rdata = 8'h00;
    tick_hit = (cur.tick == 16'(RAMP_CYC - 1));
    nxt.tick = tick_hit ? 16'h0000 : cur.tick + 16'h0001;

    // Pin codes reach an image only through the de-bouncer and only while
    // the IO rail is up; the images always record the pins, whatever the
    // source bit says, so software can see what the processor asked for.
    if (deb_accept && IO_RAIL_EN) // RULE7
    begin
      unique case (sel) // RULE1
        SEL_CORE:
          nxt.image[0] = code; // RULE9
        SEL_NEST:
          nxt.image[1] = code; // RULE1
        SEL_INVALID,
        SEL_UNUSED:
          nxt.image = cur.image; // RULE2 RULE16
      endcase
    end

    // The setpoint registers always store what is written; with the source
    // bit clear the stored code simply has no effect on the rail.
    if (REG_WR)
    begin
      case (REG_ADDR)
        `VIR_ADDR_CORE_LATCH:
          nxt.latch[0] = REG_WDATA;
        `VIR_ADDR_NEST_LATCH:
          nxt.latch[1] = REG_WDATA;
        default:
          nxt.latch = cur.latch;
      endcase
    end

    for (int r = 0; r < 2; r++)
    begin
      old_tgt[r] = target_of(cur.latch[r], cur.image[r]);
      new_tgt[r] = target_of(nxt.latch[r], nxt.image[r]); // RULE14

      // Only a register write that moves a register-sourced target starts a
      // completion cycle; pin-driven moves leave the done output alone.
      spi_set[r] = REG_WR && (REG_ADDR == latch_addr[r]) && nxt.latch[r][`VIR_SRC_BIT]
                   && (new_tgt[r] != old_tgt[r]); // RULE15

      // One code step per tick gives the slew; a held target holds the rail.
      if (tick_hit && cur.ramp[r] < new_tgt[r])
        nxt.ramp[r] = cur.ramp[r] + 7'h01; // RULE11
      else if (tick_hit && cur.ramp[r] > new_tgt[r])
        nxt.ramp[r] = cur.ramp[r] - 7'h01; // RULE11
      else
        nxt.ramp[r] = cur.ramp[r]; // RULE16

      // A new request wins over the completion of an older one.
      nxt.pend[r]  = spi_set[r] | (cur.pend[r] & (nxt.ramp[r] != new_tgt[r])); // RULE15
      nxt.setpt[r] = code_to_setpoint(nxt.ramp[r]); // RULE13
      nxt.on[r]    = (nxt.ramp[r] <= `VIR_CODE_LAST_ON); // RULE13
    end

    nxt.done = ~|nxt.pend; // RULE15

    // Reads return one cycle after the strobe; bit 7 of an image is zero.
    if (REG_RD)
    begin
      case (REG_ADDR)
        `VIR_ADDR_CORE_IMAGE:
          nxt.rdata = {1'b0, cur.image[0]}; // RULE12
        `VIR_ADDR_NEST_IMAGE:
          nxt.rdata = {1'b0, cur.image[1]}; // RULE12
        `VIR_ADDR_CORE_LATCH:
          nxt.rdata = cur.latch[0];
        `VIR_ADDR_NEST_LATCH:
          nxt.rdata = cur.latch[1];
        default:
          nxt.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cur <= STATE_RST; // RULE12
    end
    else
    begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign REG_RDATA       = cur.rdata;
  assign CORE_SETPOINT   = cur.setpt[0];
  assign CORE_ON         = cur.on[0];
  assign NEST_SETPOINT   = cur.setpt[1];
  assign NEST_ON         = cur.on[1];
  assign REGULATION_DONE = cur.done;

endmodule : vir_receiver

`default_nettype wire

// ===== vir_receiver_assertions.sv
/*
  Checker for the voltage-code receiver, bound to its top module.
  Assumes RAMP_CYC is the one handed to the bound instance.
*/
`default_nettype none

module vir_receiver_checker #(
  parameter int RAMP_CYC = 10000
)
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Register access
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [8:0]  REG_ADDR,
  input wire logic [7:0]  REG_RDATA,
  // Rail outputs
  input wire logic [13:0] CORE_SETPOINT,
  input wire logic        CORE_ON,
  input wire logic [13:0] NEST_SETPOINT,
  input wire logic        NEST_ON,
  input wire logic        REGULATION_DONE
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  logic [15:0] gap;

  // Saturates, so a move soon after reset is never taken for a fast ramp.
  always_ff @(posedge CLK)
    if (RST) gap <= 16'hFFFF;
    else if ($changed(CORE_SETPOINT)) gap <= 16'h0000;
    else if (gap != 16'hFFFF) gap <= gap + 16'h0001;

  //////////////////////////////////////////////////////////////////////////////
  property p_rdata_idle; !REG_RD |=> REG_RDATA == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_image_rsvd; REG_RD && REG_ADDR inside {9'h1C9, 9'h1CA} |=> !REG_RDATA[7]; endproperty
  a_image_rsvd: assert property (p_image_rsvd) else $error("image bit 7 set");
  property p_core_step; CORE_ON && $past(CORE_ON) && $changed(CORE_SETPOINT) |->
    (CORE_SETPOINT - $past(CORE_SETPOINT)) == 14'h007D ||
    ($past(CORE_SETPOINT) - CORE_SETPOINT) == 14'h007D; endproperty
  a_core_step: assert property (p_core_step) else $error("core step size");
  property p_nest_step; NEST_ON && $past(NEST_ON) && $changed(NEST_SETPOINT) |->
    (NEST_SETPOINT - $past(NEST_SETPOINT)) == 14'h007D ||
    ($past(NEST_SETPOINT) - NEST_SETPOINT) == 14'h007D; endproperty
  a_nest_step: assert property (p_nest_step) else $error("nest step size");
  property p_core_rng; CORE_ON |-> CORE_SETPOINT inside {[14'h0BB8:14'h2EE0]}; endproperty
  a_core_rng: assert property (p_core_rng) else $error("core out of range");
  property p_nest_rng; NEST_ON |-> NEST_SETPOINT inside {[14'h0BB8:14'h2EE0]}; endproperty
  a_nest_rng: assert property (p_nest_rng) else $error("nest out of range");
  property p_core_slew; $changed(CORE_SETPOINT) |-> gap >= RAMP_CYC - 1; endproperty
  a_core_slew: assert property (p_core_slew) else $error("core ramps too fast");
  property p_done_src; $fell(REGULATION_DONE) |-> $past(REG_WR); endproperty
  a_done_src: assert property (p_done_src) else $error("done fell without write");

  c_write: cover property (REG_WR && REG_ADDR == 9'h1CB);
  c_done: cover property ($fell(REGULATION_DONE));
  c_step: cover property ($changed(CORE_SETPOINT) && CORE_ON);
endmodule : vir_receiver_checker

bind vir_receiver vir_receiver_checker #(.RAMP_CYC(RAMP_CYC)) u_chk (
  .CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_RDATA(REG_RDATA), .CORE_SETPOINT(CORE_SETPOINT), .CORE_ON(CORE_ON),
  .NEST_SETPOINT(NEST_SETPOINT), .NEST_ON(NEST_ON), .REGULATION_DONE(REGULATION_DONE));

`default_nettype wire

// ===== vir_cpu_model.sv
/*
  Processor model driving the shared select and voltage-code pins.
  Assumes one caller at a time; the caller picks each hold length.
*/
`default_nettype none

module vir_cpu_model
(
  input  wire logic       CLK,
  output var  logic [1:0] RAIL_SELECT_CODE,
  output var  logic [6:0] VOLTAGE_CODE
);
  timeunit 1ns;
  timeprecision 100ps;

  initial RAIL_SELECT_CODE = 2'b00;
  initial VOLTAGE_CODE = 7'h7F;

  // Invalid select floats the code pins, so they wander every cycle.
  task automatic present(input logic [1:0] sel, input logic [6:0] code, input int cyc);
    repeat (cyc)
    begin
      @(posedge CLK);
      #2;
      RAIL_SELECT_CODE = sel;
      VOLTAGE_CODE = (sel == 2'b00) ? ~VOLTAGE_CODE : code;
    end
  endtask : present
endmodule : vir_cpu_model

`default_nettype wire

// ===== vir_receiver_test.sv
/*
  Self-checking bench for the voltage-code receiver.
  Assumes the checker binds itself and RAMP_CYC is shortened to 4.
*/
`default_nettype none

module vir_receiver_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0, rst = 1'b1, io_en = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [8:0]  addr = 9'h000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [1:0]  sel;
  logic [6:0]  code;
  logic [13:0] core_sp, nest_sp;
  logic        core_on, nest_on, done;
  int          err_total = 0, n_compared = 0;
  logic [6:0]  tcode [4] = '{7'h00, 7'h40, 7'h60, 7'h61};
  logic [13:0] tsp [4] = '{14'h2EE0, 14'h1B58, 14'h0BB8, 14'h0000};

  always #25 clk = ~clk;

  vir_cpu_model cpu (.CLK(clk), .RAIL_SELECT_CODE(sel), .VOLTAGE_CODE(code));
  vir_receiver #(.RAMP_CYC(4)) dut (
    .CLK(clk), .RST(rst), .RAIL_SELECT_CODE(sel), .VOLTAGE_CODE(code), .IO_RAIL_EN(io_en),
    .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .CORE_SETPOINT(core_sp), .CORE_ON(core_on), .NEST_SETPOINT(nest_sp), .NEST_ON(nest_on),
    .REGULATION_DONE(done));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (!ok)
    begin
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  // A read compares against d; a write stores d.
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(posedge clk);
    #2;
    {wr, rd} = 2'b00;
    if (!w) chk(rdata === d, "read data");
  endtask : acc

  task automatic settle;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      #2;
      n++;
    end
    chk(done === 1'b1, "ramp never done");
  endtask : settle

  task automatic test_done;
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    #2;
    rst = 1'b0;
    acc(1, 9'h1CB, 8'h20);
    acc(1, 9'h1CC, 8'h30);
    acc(0, 9'h1C9, 8'h7F);
    acc(0, 9'h1CB, 8'h20);
    acc(0, 9'h1CC, 8'h30);
    acc(0, 9'h100, 8'h00);
    acc(1, 9'h1C9, 8'h55);
    acc(0, 9'h1C9, 8'h7F);
    cpu.present(2'b10, 7'h31, 12);
    cpu.present(2'b00, 7'h00, 12);
    acc(0, 9'h1CA, 8'h7F);
    io_en = 1'b1;
    cpu.present(2'b10, 7'h30, 12);
    cpu.present(2'b00, 7'h00, 12);
    acc(0, 9'h1C9, 8'h7F);
    cpu.present(2'b01, 7'h20, 12);
    acc(0, 9'h1CA, 8'h30);
    acc(0, 9'h1C9, 8'h20);
    cpu.present(2'b11, 7'h10, 12);
    acc(0, 9'h1C9, 8'h20);
    acc(0, 9'h1CA, 8'h30);
    cpu.present(2'b01, 7'h21, 3);
    cpu.present(2'b01, 7'h20, 12);
    acc(0, 9'h1C9, 8'h20);
    cpu.present(2'b01, 7'h21, 12);
    acc(0, 9'h1C9, 8'h21);
    repeat (500) @(posedge clk);
    #2;
    chk(core_sp === 14'h2A7B, "core setpoint");
    chk(nest_sp === 14'h2328, "nest setpoint");
    chk(done === 1'b1, "done moved on pins");
    acc(1, 9'h1CC, 8'h10);
    chk(done === 1'b1, "done moved on ignored write");
    acc(1, 9'h1CC, 8'hB1);
    chk(done === 1'b0, "nest done stayed high");
    settle;
    chk(nest_sp === 14'h22AB, "nest latched setpoint");
    chk(nest_on === 1'b1, "nest rail on");
    acc(1, 9'h1CB, 8'hA2);
    chk(done === 1'b0, "done stayed high");
    settle;
    chk(core_sp === 14'h29FE, "latched setpoint");
    cpu.present(2'b01, 7'h20, 12);
    acc(0, 9'h1C9, 8'h20);
    chk(core_sp === 14'h29FE, "pins steered rail");
    acc(0, 9'h1CB, 8'hA2);
    for (int i = 0; i < 4; i++)
    begin
      acc(1, 9'h1CB, {1'b1, tcode[i]});
      settle;
      chk(core_on === (i < 3), "rail on");
      if (i < 3) chk(core_sp === tsp[i], "code setpoint");
    end
    test_done;
  end

  initial
  begin
    #400000;
    err_total++;
    test_done;
  end
endmodule : vir_receiver_test

`default_nettype wire
